// [core/pesd_pkg.sv]
// Package: event codes, field positions and carriers for the event decoder
package pesd_pkg;

    // Event-select register fields
    localparam int ESC_CODE_HI = 31;
    localparam int ESC_CODE_LO = 25;
    localparam int ESC_CODE6_HI = 30;
    localparam int ESC_MASK_HI = 24;
    localparam int ESC_MASK_LO = 9;
    // Counter-configuration selector field
    localparam int CCR_SEL_HI = 15;
    localparam int CCR_SEL_LO = 13;

    // Event codes
    localparam logic [6:0] CODE_ROM_XFER = 7'h05;
    localparam logic [6:0] CODE_QUEUE_WR = 7'h09;
    localparam logic [5:0] CODE_MISPRED = 6'h05;
    localparam logic [5:0] CODE_BRANCH = 6'h04;
    localparam logic [5:0] CODE_STALL = 6'h01;
    localparam logic [5:0] CODE_WCB = 6'h05;

    // Configuration selectors
    localparam logic [2:0] SEL_FRONT = 3'h0;
    localparam logic [2:0] SEL_BRANCH = 3'h2;
    localparam logic [2:0] SEL_STALL = 3'h1;

    // Mask bit positions
    localparam int rom_transfer_bit = 0;
    localparam int source_build_bit = 0;
    localparam int source_deliver_bit = 1;
    localparam int source_rom_bit = 2;
    localparam int cond_bit = 1;
    localparam int call_bit = 2;
    localparam int return_bit = 3;
    localparam int indirect_bit = 4;
    localparam int store_buffer_full_bit = 5;
    localparam int any_eviction_bit = 0;
    localparam int no_buffer_eviction_bit = 1;

    // Counter numbers per event-select register
    localparam logic [4:0] CNT_FRONT_A0 = 5'h04;
    localparam logic [4:0] CNT_FRONT_B0 = 5'h06;
    localparam logic [4:0] CNT_WCB_A0 = 5'h08;
    localparam logic [4:0] CNT_WCB_B0 = 5'h0A;
    localparam logic [4:0] CNT_NONE = 5'h1F;

    // Event source group, one pulse per occurrence
    typedef struct packed {
        logic romXfer;
        logic qwBuild;
        logic qwDeliver;
        logic qwRom;
        logic brCond;
        logic brDirCall;
        logic brIndCall;
        logic brReturn;
        logic brIndJump;
        logic brMispred;
        logic stallSb;
        logic wcbEvict;
        logic wcbFullEvict;
    } pesd_evt_s;

    typedef enum logic [6:0] {
        UNIT_NONE = 7'h01,
        UNIT_ROM = 7'h02,
        UNIT_QUEUE = 7'h04,
        UNIT_MISP = 7'h08,
        UNIT_BRANCH = 7'h10,
        UNIT_STALL = 7'h20,
        UNIT_WCB = 7'h40
    } pesd_unit_e;

    // Which event-select register a programming applies to
    typedef enum logic [2:0] {
        REG_ROM = 3'h1,
        REG_BRANCH = 3'h2,
        REG_OTHER = 3'h4
    } pesd_reg_e;

endpackage

// [core/pesd_count_pair.sv]
// Module: counter-pair index for a chosen event-select register
`timescale 1ns/10ps
`default_nettype none

module pesd_count_pair (
    input wire logic [4:0] baseA,
    input wire logic [4:0] baseB,
    input wire logic selSecond,
    output logic [4:0] firstCounter
);
    always_comb begin
        firstCounter = selSecond ? baseB : baseA;
    end
endmodule // pesd_count_pair

`default_nettype wire

// [core/pesd_decoder.sv]
// Module: performance-event select decoder and increment generator
`timescale 1ns/10ps
`default_nettype none

module pesd_decoder
    import pesd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] event_select_control_reg,
    input wire logic [31:0] counter_config_control_reg,
    input wire pesd_pkg::pesd_reg_e regKind,
    input wire logic regSecond,
    input wire pesd_pkg::pesd_evt_s evtIn,
    output logic [1:0] incAmount_r,
    output logic [4:0] counterIdx_r,
    output logic eventValid_r,
    output pesd_pkg::pesd_unit_e unit_r
);
    import pesd_pkg::*;

    // ****************************************
    // Field extraction
    // ****************************************
    logic [6:0] code7;
    logic [5:0] code6;
    logic [15:0] evMask;
    logic [2:0] ccSel;
    logic [4:0] frontBase;
    logic [4:0] wcbBase;

    assign code7 = event_select_control_reg[ESC_CODE_HI:ESC_CODE_LO];
    assign code6 = event_select_control_reg[ESC_CODE6_HI:ESC_CODE_LO];
    assign evMask = event_select_control_reg[ESC_MASK_HI:ESC_MASK_LO];
    assign ccSel = counter_config_control_reg[CCR_SEL_HI:CCR_SEL_LO];

    pesd_count_pair uFront (
        .baseA(CNT_FRONT_A0),
        .baseB(CNT_FRONT_B0),
        .selSecond(regSecond),
        .firstCounter(frontBase)
    );

    pesd_count_pair uWcb (
        .baseA(CNT_WCB_A0),
        .baseB(CNT_WCB_B0),
        .selSecond(regSecond),
        .firstCounter(wcbBase)
    );

    // ****************************************
    // Event selection
    // ****************************************
    // Branch, stall and write-combine codes sit in a six-bit field;
    // bit 31 is not part of their code and is ignored for them
    logic romSel;
    logic queueSel;
    logic mispSel;
    logic branchSel;
    logic stallSel;
    logic wcbSel;

    assign romSel = (ccSel == SEL_FRONT) && (code7 == CODE_ROM_XFER);
    assign queueSel = (ccSel == SEL_FRONT) && (code7 == CODE_QUEUE_WR);
    assign mispSel = (ccSel == SEL_BRANCH) && (code6 == CODE_MISPRED);
    assign branchSel = (ccSel == SEL_BRANCH) && (code6 == CODE_BRANCH);
    assign stallSel = (ccSel == SEL_STALL) && (code6 == CODE_STALL);
    // No selector is given for write-combine operations; code alone picks it
    assign wcbSel = (code6 == CODE_WCB);

    // ****************************************
    // Sub-event qualification
    // ****************************************
    logic romHit;
    logic qwBuildHit;
    logic qwDeliverHit;
    logic qwRomHit;
    logic anyIndirect;
    logic brCondHit;
    logic mispCallHit;
    logic brCallHit;
    logic brReturnHit;
    logic brIndHit;
    logic mispHit;
    logic branchHit;
    logic stallHit;
    logic wcbHit;

    always_comb begin
        romHit = evMask[rom_transfer_bit] & evtIn.romXfer;
        qwBuildHit = evMask[source_build_bit] & evtIn.qwBuild;
        qwDeliverHit = evMask[source_deliver_bit] & evtIn.qwDeliver;
        qwRomHit = evMask[source_rom_bit] & evtIn.qwRom;
        // Bit 4 overlaps bits 2 and 3; a branch hit by both counts once
        anyIndirect = evtIn.brReturn | evtIn.brIndCall | evtIn.brIndJump;
        brCondHit = evMask[cond_bit] & evtIn.brCond;
        brReturnHit = evMask[return_bit] & evtIn.brReturn;
        brIndHit = evMask[indirect_bit] & anyIndirect;
        // Mispredict bit 2 takes indirect calls only
        mispCallHit = evMask[call_bit] & evtIn.brIndCall;
        brCallHit = evMask[call_bit]
            & (evtIn.brDirCall | evtIn.brIndCall);
        // Spurious conditionals from rebuilds or clears pass straight on
        mispHit = evtIn.brMispred
            & (brCondHit | mispCallHit | brReturnHit | brIndHit);
        branchHit = brCondHit | brCallHit | brReturnHit | brIndHit;
        stallHit = evMask[store_buffer_full_bit] & evtIn.stallSb;
        wcbHit = (evMask[any_eviction_bit] & evtIn.wcbEvict)
            | (evMask[no_buffer_eviction_bit] & evtIn.wcbFullEvict);
    end

    // ****************************************
    // Decode and increment
    // ****************************************
    pesd_unit_e unit_nxt;
    logic [1:0] incAmount_nxt;
    logic [4:0] counterIdx_nxt;
    logic eventValid_nxt;
    logic [2:0] hits;

    always_comb begin
        unit_nxt = UNIT_NONE;
        counterIdx_nxt = CNT_NONE;
        hits = 3'h0;
        case (regKind)
            REG_ROM: begin
                if (romSel) begin
                    unit_nxt = UNIT_ROM;
                end else if (queueSel) begin
                    unit_nxt = UNIT_QUEUE;
                end
                // Both front families keep their pair even when idle
                counterIdx_nxt = frontBase;
            end
            REG_BRANCH: begin
                if (mispSel) begin
                    unit_nxt = UNIT_MISP;
                end else if (branchSel) begin
                    unit_nxt = UNIT_BRANCH;
                end
                counterIdx_nxt = frontBase;
            end
            REG_OTHER: begin
                // Stall counters lie outside the pairs this block drives
                if (stallSel) begin
                    unit_nxt = UNIT_STALL;
                    counterIdx_nxt = CNT_NONE;
                end else if (wcbSel) begin
                    unit_nxt = UNIT_WCB;
                    counterIdx_nxt = wcbBase;
                end
            end
            default: begin
                unit_nxt = UNIT_NONE;
            end
        endcase

        case (unit_nxt)
            UNIT_ROM: begin
                hits[0] = romHit;
            end
            UNIT_QUEUE: begin
                hits[0] = qwBuildHit;
                hits[1] = qwDeliverHit;
                hits[2] = qwRomHit;
            end
            UNIT_MISP: begin
                // Only mispredicted retirements reach this count
                hits[0] = mispHit;
            end
            UNIT_BRANCH: begin
                hits[0] = branchHit;
            end
            UNIT_STALL: begin
                hits[0] = stallHit;
            end
            UNIT_WCB: begin
                hits[0] = wcbHit;
            end
            default: begin
                hits = 3'h0;
            end
        endcase
        // One increment per qualifying micro-op source; one per occurrence
        incAmount_nxt = 2'({1'b0, hits[0]} + {1'b0, hits[1]})
            + {1'b0, hits[2]};
        eventValid_nxt = (unit_nxt != UNIT_NONE);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unit_r <= UNIT_NONE;
            incAmount_r <= 2'h0;
            counterIdx_r <= CNT_NONE;
            eventValid_r <= 1'b0;
        end else begin
            unit_r <= unit_nxt;
            incAmount_r <= incAmount_nxt;
            counterIdx_r <= counterIdx_nxt;
            eventValid_r <= eventValid_nxt;
        end
    end

endmodule // pesd_decoder

`default_nettype wire

// [tb/pesd_decoder_assertions.sv]
// Checker: timing and decode properties at the decoder ports
`timescale 1ns/10ps
`default_nettype none
module pesd_decoder_assertions
    import pesd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] event_select_control_reg,
    input wire logic [31:0] counter_config_control_reg,
    input wire pesd_pkg::pesd_reg_e regKind,
    input wire logic regSecond,
    input wire pesd_pkg::pesd_evt_s evtIn,
    input wire logic [1:0] incAmount_r,
    input wire logic [4:0] counterIdx_r,
    input wire logic eventValid_r,
    input wire pesd_pkg::pesd_unit_e unit_r
);
    // ****
    // Decode helpers
    // ****
    wire [31:0] esc = event_select_control_reg;
    wire [2:0] q = counter_config_control_reg[15:13];
    wire [6:0] c7 = esc[31:25];
    wire [5:0] c6 = esc[30:25];
    wire rh = esc[9] & evtIn.romXfer;
    wire sh = esc[14] & evtIn.stallSb;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rom_xfer_a: assert property (
        regKind == REG_ROM && q == 3'h0 && c7 == 7'h05 |=>
        unit_r == UNIT_ROM && incAmount_r == {1'b0, $past(rh)})
        else $error("rom transfer decode wrong");
    queue_sel_a: assert property (
        regKind == REG_ROM && c7 == 7'h09 |=>
        (unit_r == UNIT_QUEUE) == ($past(q) == 3'h0))
        else $error("queue write selector wrong");
    mispred_a: assert property (
        regKind == REG_BRANCH && q == 3'h2 && c6 == 6'h05 |=>
        unit_r == UNIT_MISP) else $error("mispredict decode wrong");
    branch_kind_a: assert property (
        regKind == REG_BRANCH && q == 3'h2 && c6 == 6'h04 |=>
        unit_r == UNIT_BRANCH) else $error("branch decode wrong");
    stall_sb_a: assert property (
        regKind == REG_OTHER && q == 3'h1 && c6 == 6'h01 |=>
        unit_r == UNIT_STALL && incAmount_r == {1'b0, $past(sh)})
        else $error("stall decode wrong");
    wcb_pair_a: assert property (
        regKind == REG_OTHER && c6 == 6'h05 |=> unit_r == UNIT_WCB &&
        counterIdx_r == ($past(regSecond) ? 5'h0A : 5'h08))
        else $error("write combine pair wrong");
    front_pair_a: assert property (
        unit_r inside {UNIT_ROM, UNIT_QUEUE, UNIT_MISP, UNIT_BRANCH} |->
        counterIdx_r == ($past(regSecond) ? 5'h06 : 5'h04))
        else $error("front counter pair wrong");
    quiet_none_a: assert property (
        unit_r == UNIT_NONE |-> incAmount_r == 2'h0 && !eventValid_r)
        else $error("idle decode not quiet");
endmodule // pesd_decoder_assertions
bind pesd_decoder pesd_decoder_assertions i_chk (.mclk(mclk),
    .rst_n(rst_n), .event_select_control_reg(event_select_control_reg),
    .counter_config_control_reg(counter_config_control_reg),
    .regKind(regKind), .regSecond(regSecond), .evtIn(evtIn),
    .incAmount_r(incAmount_r), .counterIdx_r(counterIdx_r),
    .eventValid_r(eventValid_r), .unit_r(unit_r));
`default_nettype wire

// [tb/tb_pesd_decoder.sv]
// Testbench: directed and random decode checks of the event decoder
`timescale 1ns/10ps
`default_nettype none
module tb_pesd_decoder;
    import pesd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] esc = '0;
    logic [31:0] cfg = '0;
    pesd_reg_e kind = REG_ROM;
    logic sec = 1'b0;
    pesd_evt_s evt = '0;
    logic [1:0] inc;
    logic [4:0] idx;
    logic vld;
    pesd_unit_e unit;
    logic [13:0] expV;
    logic armed = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    integer seed = 32'h9F3C;
    pesd_reg_e kinds[6] = '{REG_ROM, REG_ROM, REG_BRANCH, REG_BRANCH,
        REG_OTHER, REG_OTHER};
    logic [6:0] codes[6] = '{7'h05, 7'h09, 7'h05, 7'h04, 7'h01, 7'h05};
    logic [2:0] sels[6] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h0};
    pesd_decoder i_dut (.mclk(mclk), .rst_n(rst_n),
        .event_select_control_reg(esc), .counter_config_control_reg(cfg),
        .regKind(kind), .regSecond(sec), .evtIn(evt), .incAmount_r(inc),
        .counterIdx_r(idx), .eventValid_r(vld), .unit_r(unit));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ****
    // Expected {unit, increment, counter} from the inputs
    // ****
    function automatic logic [13:0] model(pesd_reg_e k, logic s,
        logic [31:0] e, logic [2:0] q, pesd_evt_s v);
        logic [15:0] m;
        logic [6:0] u;
        logic [1:0] n;
        logic i;
        m = e[24:9];
        u = 7'h01;
        n = 2'h0;
        i = v.brReturn | v.brIndCall | v.brIndJump;
        if (k == REG_ROM && q == 3'h0 && e[31:25] == 7'h05) begin
            u = 7'h02;
            n = 2'(m[0] & v.romXfer);
        end else if (k == REG_ROM && q == 3'h0 && e[31:25] == 7'h09) begin
            u = 7'h04;
            n = 2'(m[0] & v.qwBuild) + 2'(m[1] & v.qwDeliver);
            n = n + 2'(m[2] & v.qwRom);
        end else if (k == REG_BRANCH && q == 3'h2 && e[30:25] == 6'h05) begin
            u = 7'h08;
            n = 2'(v.brMispred & (m[1] & v.brCond | m[2] & v.brIndCall |
                m[3] & v.brReturn | m[4] & i));
        end else if (k == REG_BRANCH && q == 3'h2 && e[30:25] == 6'h04) begin
            u = 7'h10;
            n = 2'(m[1] & v.brCond | m[2] & (v.brDirCall | v.brIndCall) |
                m[3] & v.brReturn | m[4] & i);
        end else if (k == REG_OTHER && q == 3'h1 && e[30:25] == 6'h01) begin
            u = 7'h20;
            n = 2'(m[5] & v.stallSb);
        end else if (k == REG_OTHER && e[30:25] == 6'h05) begin
            u = 7'h40;
            n = 2'(m[0] & v.wcbEvict | m[1] & v.wcbFullEvict);
        end
        // Front families name their pair even with no event chosen
        return {u, n, (u == 7'h40) ? (s ? 5'h0A : 5'h08) :
            (k == REG_OTHER) ? 5'h1F : (s ? 5'h06 : 5'h04)};
    endfunction
    task automatic chk(input string nm, input logic [6:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // One cycle of latency: check last inputs, then drive new ones
    task automatic step(input pesd_reg_e k, input logic s,
        input logic [31:0] e, input logic [2:0] q, input pesd_evt_s v);
        @(negedge mclk);
        if (armed) begin
            chk("unit", expV[13:7], unit);
            chk("inc", 7'(expV[6:5]), 7'(inc));
            chk("inc2", 7'(expV[6:5]), 7'(inc));
            chk("idx", 7'(expV[4:0]), 7'(idx));
            chk("valid", 7'(expV[13:7] != 7'h01), 7'(vld));
        end
        kind = k;
        sec = s;
        esc = e;
        cfg = {16'h0, q, 13'h0};
        evt = v;
        expV = model(k, s, e, q, v);
        armed = 1'b1;
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [31:0] e;
        pesd_evt_s v;
        int j;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        // Build and ROM sources together add two
        step(REG_ROM, 1'b0, {7'h09, 16'h0007, 9'h0}, 3'h0, 13'h0A00);
        for (int i = 0; i < 6; i++)
            for (int b = 0; b < 6; b++)
                step(kinds[i], b[0], {codes[i], 16'(1 << b), 9'h0}, sels[i],
                    '1);
        for (int n = 0; n < 2000; n++) begin
            j = {$random(seed)} % 6;
            e = $random(seed);
            if (e[0])
                e[31:25] = codes[j];
            v = pesd_evt_s'(13'($random(seed)));
            // A full eviction is an eviction too
            v.wcbEvict |= v.wcbFullEvict;
            step(kinds[j], e[1], e, e[2] ? sels[j] : 3'($random(seed)), v);
        end
        @(negedge mclk);
        rst_n = 1'b0;
        armed = 1'b0;
        @(negedge mclk);
        chk("rst unit", 7'h01, unit);
        chk("rst idx", 7'h1F, 7'(idx));
        rst_n = 1'b1;
        step(REG_OTHER, 1'b1, {7'h05, 16'h0003, 9'h0}, 3'h7, '1);
        step(REG_ROM, 1'b1, {7'h05, 16'h0001, 9'h0}, 3'h0, '1);
        step(REG_ROM, 1'b0, '0, 3'h0, '0);
        wrap_up();
    end
endmodule // tb_pesd_decoder
`default_nettype wire
